//--- hdl/ieq_defines.vh
`ifndef IEQ_DEFINES_VH
`define IEQ_DEFINES_VH

// Register byte offsets
`define IEQ_OFS_CTRL 12'h000
`define IEQ_OFS_INJECT 12'h004
`define IEQ_OFS_POP 12'h008
`define IEQ_OFS_STATUS 12'h00C
`define IEQ_OFS_ESR 12'h010
`define IEQ_OFS_EVENT 12'h014

// Control bits
`define IEQ_CTRL_CLS 0
`define IEQ_CTRL_TALK 1

// Event register bits (parser and output-queue events)
`define IEQ_EV_GET 0
`define IEQ_EV_LONG 1
`define IEQ_EV_DIGITS 2
`define IEQ_EV_EXTRA 3
`define IEQ_EV_MISSING 4
`define IEQ_EV_STRING 5
`define IEQ_EV_SYNTAX 6
`define IEQ_EV_NOOUT 7
`define IEQ_EV_LOST 8

// Event status register bit positions
`define IEQ_ESR_CMD 5
`define IEQ_ESR_EXE 4
`define IEQ_ESR_DEV 3
`define IEQ_ESR_QRY 2

// Error codes
`define IEQ_CODE_NONE 16'h0000
`define IEQ_CODE_OVF 16'hFEA2
`define IEQ_CODE_CMD 16'hFF9C
`define IEQ_CODE_GET 16'hFF97
`define IEQ_CODE_EXTRA 16'hFF94
`define IEQ_CODE_MISSING 16'hFF93
`define IEQ_CODE_LONG 16'hFF90
`define IEQ_CODE_DIGITS 16'hFF84
`define IEQ_CODE_STRING 16'hFF69
`define IEQ_CODE_QRY 16'hFE70
`define IEQ_CODE_LOST 16'hFE6E

// Limits and sizes
`define IEQ_DEPTH 30
`define IEQ_MAX_NAME 12
`define IEQ_MAX_DIGITS 255

`endif

//--- hdl/ieq_classify.v
`timescale 1ns/1ps
`include "ieq_defines.vh"

// Maps a signed code to one error class bit per range
module ieq_classify (
   // Code in
   input wire [15:0] code,
   // Class out
   output reg is_cmd,
   output reg is_exe,
   output reg is_dev,
   output reg is_qry
);

   wire signed [15:0] c = code;

   always @* begin
      is_cmd = (c <= -16'sd100) && (c >= -16'sd199);
      is_exe = (c <= -16'sd200) && (c >= -16'sd299);
      // Positive codes up to the top of the 16-bit range are device class
      is_dev = ((c <= -16'sd300) && (c >= -16'sd399)) || (c > 16'sd0);
      is_qry = (c <= -16'sd400) && (c >= -16'sd499);
   end

endmodule // ieq_classify

//--- hdl/ieq_fifo.v
`timescale 1ns/1ps
`include "ieq_defines.vh"

// Error code FIFO; the last slot only ever holds the overflow code
module ieq_fifo #(
   parameter DEPTH = `IEQ_DEPTH,
   parameter AW = 5
) (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // Control
   input wire clear,
   input wire push,
   input wire [15:0] push_code,
   input wire pop,
   // State
   output wire [15:0] head,
   output reg [AW:0] count_r,
   output wire empty
);

   reg [15:0] mem [0:DEPTH-1];
   reg [AW-1:0] rd_r;
   reg [AW-1:0] wr_r;
   wire full = (count_r == DEPTH[AW:0]);
   wire last_free = (count_r == DEPTH[AW:0] - 1'b1);
   wire do_pop = pop && !empty;
   wire do_push = push && !full && !(last_free && do_pop);
   wire [15:0] wcode = last_free ? `IEQ_CODE_OVF : push_code;

   assign empty = (count_r == {(AW+1){1'b0}});
   assign head = empty ? `IEQ_CODE_NONE : mem[rd_r];

   function [AW-1:0] inc;
      input [AW-1:0] p;
      begin
         inc = (p == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : p + 1'b1;
      end
   endfunction

   always @(posedge hclk) begin
      if (do_push) begin
         mem[wr_r] <= wcode;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_r <= {AW{1'b0}};
         wr_r <= {AW{1'b0}};
         count_r <= {(AW+1){1'b0}};
      end else if (clear) begin
         rd_r <= {AW{1'b0}};
         wr_r <= {AW{1'b0}};
         count_r <= {(AW+1){1'b0}};
      end else begin
         // Push to tail, pop from head, oldest first
         if (do_push) begin
            wr_r <= inc(wr_r);
         end
         if (do_pop) begin
            rd_r <= inc(rd_r);
         end
         // Pushes into a full queue are dropped
         if (do_push && !do_pop) begin
            count_r <= count_r + 1'b1;
         end else if (do_pop && !do_push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end

endmodule // ieq_fifo

//--- hdl/ieq_top.v
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "ieq_defines.vh"

module ieq_top #(
   parameter DEPTH = `IEQ_DEPTH,
   parameter AW = 5
) (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // AHB-Lite slave
   input wire hsel,
   input wire [11:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   // Error sources from parser, execution, device and output queue
   input wire parse_valid,
   input wire [4:0] parse_kind,
   input wire [7:0] name_len,
   input wire [8:0] digit_count,
   input wire exe_valid,
   input wire exe_rounded,
   input wire [15:0] exe_code,
   input wire dev_valid,
   input wire [15:0] dev_code,
   input wire read_no_output,
   input wire output_lost,
   // Talk-only to addressed switch from front panel
   input wire talk_to_addressed,
   // Event status bits
   output reg [7:0] esr_bits_r,
   output reg queue_empty_r
);

   // Parser event kinds
   localparam K_GET = 5'h00;
   localparam K_EXTRA = 5'h01;
   localparam K_MISSING = 5'h02;
   localparam K_STRING_END = 5'h03;
   localparam K_OTHER = 5'h04;
   localparam K_NAME = 5'h05;
   localparam K_NUMBER = 5'h06;

   // Bus capture
   reg wr_pend_r;
   reg [11:0] addr_r;
   wire take = hsel && hready && htrans[1];

   // Control
   reg talk_only_r;
   reg sw_push_r;
   reg [15:0] sw_code_r;
   reg cls_r;

   // Decode a parser event into a command code or none
   function [16:0] parse_code;
      input [4:0] kind;
      input [7:0] len;
      input [8:0] digits;
      begin
         parse_code = {1'b0, `IEQ_CODE_NONE};
         case (kind)
            K_GET: parse_code = {1'b1, `IEQ_CODE_GET};
            K_EXTRA: parse_code = {1'b1, `IEQ_CODE_EXTRA};
            K_MISSING: parse_code = {1'b1, `IEQ_CODE_MISSING};
            K_STRING_END: parse_code = {1'b1, `IEQ_CODE_STRING};
            K_OTHER: parse_code = {1'b1, `IEQ_CODE_CMD};
            K_NAME: begin
               if (len > `IEQ_MAX_NAME) begin
                  parse_code = {1'b1, `IEQ_CODE_LONG};
               end
            end
            K_NUMBER: begin
               if (digits > `IEQ_MAX_DIGITS) begin
                  parse_code = {1'b1, `IEQ_CODE_DIGITS};
               end
            end
            default: parse_code = {1'b1, `IEQ_CODE_CMD};
         endcase
      end
   endfunction

   wire [16:0] pc = parse_code(parse_kind, name_len, digit_count);

   // One error accepted per cycle; parser first, then execution, device, query
   reg push;
   reg [15:0] push_code;
   always @* begin
      push = 1'b0;
      push_code = `IEQ_CODE_NONE;
      if (parse_valid && pc[16]) begin
         push = 1'b1;
         push_code = pc[15:0];
      end else if (exe_valid && exe_rounded) begin
         // Only after evaluation and rounding are done
         push = 1'b1;
         push_code = exe_code;
      end else if (dev_valid) begin
         push = 1'b1;
         push_code = dev_code;
      end else if (read_no_output || output_lost) begin
         push = 1'b1;
         push_code = output_lost ? `IEQ_CODE_LOST : `IEQ_CODE_QRY;
      end else if (sw_push_r) begin
         push = 1'b1;
         push_code = sw_code_r;
      end
   end

   wire [15:0] head;
   wire [AW:0] count;
   wire empty;
   // Pop on the address phase, so a back-to-back read sees the next head
   wire pop_now = take && !hwrite && (haddr == `IEQ_OFS_POP);
   // Mode switch clears too
   wire clear = cls_r || (talk_to_addressed && talk_only_r);

   ieq_fifo #(
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_fifo (
      .hclk(hclk),
      .hresetn(hresetn),
      .clear(clear),
      .push(push),
      .push_code(push_code),
      .pop(pop_now),
      .head(head),
      .count_r(count),
      .empty(empty)
   );

   // Classification of what lands in the queue; a push dropped by a same-cycle pop at DEPTH-1 entries still classes as overflow
   wire full = (count == DEPTH[AW:0]);
   wire [15:0] cls_code = (push && count == DEPTH[AW:0] - 1'b1) ?
      `IEQ_CODE_OVF : push_code;
   wire c_cmd;
   wire c_exe;
   wire c_dev;
   wire c_qry;

   ieq_classify u_cls (
      .code(cls_code),
      .is_cmd(c_cmd),
      .is_exe(c_exe),
      .is_dev(c_dev),
      .is_qry(c_qry)
   );

   // Status bits: a new error in the same cycle wins over the clear
   wire hit = push && !full;
   wire esr_clear = wr_pend_r && (addr_r == `IEQ_OFS_ESR);
   reg [7:0] esr_nxt;
   always @* begin
      esr_nxt = esr_clear ? (esr_bits_r & ~hwdata[7:0]) : esr_bits_r;
      if (hit && c_cmd) begin
         esr_nxt[`IEQ_ESR_CMD] = 1'b1;
      end
      if (hit && c_exe) begin
         esr_nxt[`IEQ_ESR_EXE] = 1'b1;
      end
      // Full queue counts as a device error
      if ((hit && c_dev) || (push && full)) begin
         esr_nxt[`IEQ_ESR_DEV] = 1'b1;
      end
      if (hit && c_qry) begin
         esr_nxt[`IEQ_ESR_QRY] = 1'b1;
      end
   end

   // Read mux
   reg [31:0] rdata;
   always @* begin
      case (haddr)
         `IEQ_OFS_CTRL: rdata = {30'h00000000, talk_only_r, 1'b0};
         `IEQ_OFS_POP: rdata = {{16{head[15]}}, head};
         `IEQ_OFS_STATUS: rdata = {25'h0000000, empty, count};
         `IEQ_OFS_ESR: rdata = {24'h000000, esr_bits_r};
         default: rdata = 32'h00000000;
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         addr_r <= 12'h000;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         talk_only_r <= 1'b0;
         sw_push_r <= 1'b0;
         sw_code_r <= 16'h0000;
         cls_r <= 1'b0;
         esr_bits_r <= 8'h00;
         queue_empty_r <= 1'b1;
      end else begin
         wr_pend_r <= take && hwrite;
         if (take) begin
            addr_r <= haddr;
         end
         if (take && !hwrite) begin
            hrdata <= rdata;
         end
         cls_r <= 1'b0;
         sw_push_r <= 1'b0;
         if (wr_pend_r) begin
            case (addr_r)
               `IEQ_OFS_CTRL: begin
                  cls_r <= hwdata[`IEQ_CTRL_CLS];
                  talk_only_r <= hwdata[`IEQ_CTRL_TALK];
               end
               `IEQ_OFS_INJECT: begin
                  sw_push_r <= 1'b1;
                  sw_code_r <= hwdata[15:0];
               end
               default: begin
               end
            endcase
         end
         if (talk_to_addressed) begin
            talk_only_r <= 1'b0;
         end
         esr_bits_r <= esr_nxt;
         queue_empty_r <= empty;
      end
   end

endmodule // ieq_top

//--- verif/ieq_top_chk.sv
`timescale 1ns/1ps

module ieq_top_chk #(
   parameter DEPTH = 30
) (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // Bus
   input wire hsel,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   // Error sources
   input wire parse_valid,
   input wire [4:0] parse_kind,
   input wire exe_valid,
   input wire exe_rounded,
   input wire [15:0] exe_code,
   input wire dev_valid,
   input wire read_no_output,
   input wire output_lost,
   // Status
   input wire [7:0] esr_bits_r,
   input wire queue_empty_r
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire rd_taken = hsel && hready && htrans[1] && !hwrite;
   wire upper = parse_valid || exe_valid;

   property p_ready;
      hreadyout;
   endproperty
   a_ready: assert property (p_ready) else $error("wait state seen");
   property p_okay;
      !hresp;
   endproperty
   a_okay: assert property (p_okay) else $error("error response seen");
   property p_hold;
      !rd_taken |=> $stable(hrdata);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_get;
      parse_valid && parse_kind == 5'h00 |-> ##[1:4] esr_bits_r[5];
   endproperty
   a_get: assert property (p_get) else $error("command bit not set");
   property p_fill;
      parse_valid && parse_kind == 5'h00 |-> ##[1:4] !queue_empty_r;
   endproperty
   a_fill: assert property (p_fill) else $error("trigger code lost");
   property p_exe;
      exe_valid && exe_rounded && !parse_valid &&
      $signed(exe_code) <= -200 && $signed(exe_code) >= -299
      |-> ##[1:4] esr_bits_r[4];
   endproperty
   a_exe: assert property (p_exe) else $error("execution bit not set");
   property p_noout;
      read_no_output && !upper && !dev_valid |-> ##[1:4] esr_bits_r[2];
   endproperty
   a_noout: assert property (p_noout) else $error("query bit not set");
   property p_lost;
      output_lost && !upper && !dev_valid && !read_no_output
      |-> ##[1:4] esr_bits_r[2];
   endproperty
   a_lost: assert property (p_lost) else $error("lost output not flagged");
endmodule // ieq_top_chk

bind ieq_top ieq_top_chk #(.DEPTH(DEPTH)) u_chk (.hclk(hclk),
   .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .parse_valid(parse_valid), .parse_kind(parse_kind),
   .exe_valid(exe_valid), .exe_rounded(exe_rounded), .exe_code(exe_code),
   .dev_valid(dev_valid),
   .read_no_output(read_no_output), .output_lost(output_lost),
   .esr_bits_r(esr_bits_r), .queue_empty_r(queue_empty_r));

//--- verif/ieq_src_model.sv
`timescale 1ns/1ps

// Parser, execution, device, output-queue and front-panel side: one event per call
module ieq_src_model (
   // Clock
   input wire hclk,
   // Event lines
   output wire parse_valid,
   output wire exe_valid,
   output wire dev_valid,
   output wire read_no_output,
   output wire output_lost,
   output wire talk_to_addressed,
   // Qualifiers
   output wire [4:0] parse_kind,
   output wire [7:0] name_len,
   output wire [8:0] digit_count,
   output wire exe_rounded,
   output wire [15:0] exe_code,
   output wire [15:0] dev_code
);
   reg [5:0] vld_r = 6'h00;
   reg [54:0] data_r = 55'h0;
   assign {talk_to_addressed, output_lost, read_no_output, dev_valid,
      exe_valid, parse_valid} = vld_r;
   assign {parse_kind, name_len, digit_count, exe_rounded, exe_code,
      dev_code} = data_r;
   // Qualifiers flip once released so a stale value is never reused
   task fire(input [2:0] s, input [4:0] k, input [15:0] a);
      begin
         data_r <= {k, a[7:0], a[8:0], k[0], a, a};
         vld_r <= 6'h01 << s;
         @(posedge hclk);
         data_r <= ~data_r;
         vld_r <= 6'h00;
         repeat (2) @(posedge hclk);
      end
   endtask
endmodule // ieq_src_model

//--- verif/tb_top.sv
`timescale 1ns/1ps
`include "ieq_defines.vh"

module tb_top;
   reg hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   reg [11:0] haddr = 12'h000;
   reg [1:0] htrans = 2'h0;
   reg [2:0] hsize = 3'h2;
   reg [31:0] hwdata = 32'h0, rd;
   wire [31:0] hrdata;
   wire hreadyout, hresp, pv, ev, er, dv, nq, ol, ta, qe;
   wire [4:0] pk;
   wire [7:0] nl, esr;
   wire [8:0] dc;
   wire [15:0] ec, dvc;
   integer n_errors = 0, total_checks = 0, i;
   always #10 hclk = ~hclk;
   ieq_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .parse_valid(pv),
      .parse_kind(pk), .name_len(nl), .digit_count(dc), .exe_valid(ev),
      .exe_rounded(er), .exe_code(ec), .dev_valid(dv), .dev_code(dvc),
      .read_no_output(nq), .output_lost(ol), .talk_to_addressed(ta),
      .esr_bits_r(esr), .queue_empty_r(qe));
   ieq_src_model SRC (.hclk(hclk), .parse_valid(pv), .exe_valid(ev),
      .dev_valid(dv), .read_no_output(nq), .output_lost(ol),
      .talk_to_addressed(ta), .parse_kind(pk), .name_len(nl),
      .digit_count(dc), .exe_rounded(er), .exe_code(ec), .dev_code(dvc));
   task end_of_test;
      begin
         $display("checks %0d errors %0d", total_checks, n_errors);
         if (n_errors == 0 && total_checks > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   // Bounded wait for hready sampled high at a rising edge
   task wait_rdy;
      integer n;
      begin
         n = 0;
         @(posedge hclk);
         while (hreadyout !== 1'b1) begin
            n = n + 1;
            if (n > 50) begin
               n_errors = n_errors + 1;
               end_of_test;
            end
            @(posedge hclk);
         end
      end
   endtask
   task ahb(input w, input [11:0] a, input [31:0] d);
      begin
         hsel <= 1'b1;
         haddr <= a;
         htrans <= 2'h2;
         hwrite <= w;
         wait_rdy;
         hsel <= 1'b0;
         htrans <= 2'h0;
         hwdata <= d;
         wait_rdy;
         rd = hrdata;
      end
   endtask
   task w(input [11:0] a, input [31:0] d);
      ahb(1'b1, a, d);
   endtask
   task check(input [95:0] nm, input [31:0] seen, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            $display("unexpected %0s expected %h seen %h", nm, exp, seen);
            n_errors = n_errors + 1;
         end
      end
   endtask
   task r(input [11:0] a, input [15:0] e);
      begin
         ahb(1'b0, a, 32'h0);
         check("register", rd, {{16{e[15]}}, e});
      end
   endtask
   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      r(`IEQ_OFS_STATUS, 16'h0040);
      r(`IEQ_OFS_ESR, 16'h0000);
      check("empty port", {31'h00000000, qe}, 32'h00000001);
      r(`IEQ_OFS_EVENT, 16'h0000);
      r(`IEQ_OFS_POP, `IEQ_CODE_NONE);
      r(`IEQ_OFS_STATUS, 16'h0040);
      SRC.fire(3'h0, 5'h00, 16'h0);
      SRC.fire(3'h0, 5'h01, 16'h0);
      SRC.fire(3'h0, 5'h02, 16'h0);
      SRC.fire(3'h0, 5'h03, 16'h0);
      SRC.fire(3'h0, 5'h04, 16'h0);
      SRC.fire(3'h0, 5'h05, 16'd12);
      SRC.fire(3'h0, 5'h05, 16'd13);
      SRC.fire(3'h0, 5'h06, 16'd255);
      SRC.fire(3'h0, 5'h06, 16'd256);
      check("empty port", {31'h00000000, qe}, 32'h00000000);
      r(`IEQ_OFS_ESR, 16'h0020);
      check("esr port", {24'h000000, esr}, 32'h00000020);
      r(`IEQ_OFS_POP, `IEQ_CODE_GET);
      r(`IEQ_OFS_POP, `IEQ_CODE_EXTRA);
      r(`IEQ_OFS_POP, `IEQ_CODE_MISSING);
      r(`IEQ_OFS_POP, `IEQ_CODE_STRING);
      r(`IEQ_OFS_POP, `IEQ_CODE_CMD);
      r(`IEQ_OFS_POP, `IEQ_CODE_LONG);
      r(`IEQ_OFS_POP, `IEQ_CODE_DIGITS);
      r(`IEQ_OFS_STATUS, 16'h0040);
      w(`IEQ_OFS_ESR, 32'h3C);
      SRC.fire(3'h1, 5'h00, 16'hFF38);
      SRC.fire(3'h1, 5'h01, 16'hFF38);
      SRC.fire(3'h1, 5'h01, 16'hFED5);
      r(`IEQ_OFS_ESR, 16'h0010);
      r(`IEQ_OFS_POP, 16'hFF38);
      r(`IEQ_OFS_POP, 16'hFED5);
      w(`IEQ_OFS_ESR, 32'h3C);
      SRC.fire(3'h3, 5'h00, 16'h0);
      SRC.fire(3'h4, 5'h00, 16'h0);
      r(`IEQ_OFS_ESR, 16'h0004);
      r(`IEQ_OFS_POP, `IEQ_CODE_QRY);
      r(`IEQ_OFS_POP, `IEQ_CODE_LOST);
      w(`IEQ_OFS_ESR, 32'h3C);
      SRC.fire(3'h2, 5'h00, 16'h7FFF);
      SRC.fire(3'h2, 5'h00, 16'hFED4);
      r(`IEQ_OFS_ESR, 16'h0008);
      r(`IEQ_OFS_POP, 16'h7FFF);
      r(`IEQ_OFS_POP, 16'hFED4);
      w(`IEQ_OFS_ESR, 32'h3C);
      for (i = 1; i <= 31; i = i + 1)
         w(`IEQ_OFS_INJECT, i);
      r(`IEQ_OFS_STATUS, 16'd30);
      r(`IEQ_OFS_ESR, 16'h0008);
      for (i = 1; i <= 29; i = i + 1)
         r(`IEQ_OFS_POP, i);
      r(`IEQ_OFS_POP, `IEQ_CODE_OVF);
      r(`IEQ_OFS_POP, `IEQ_CODE_NONE);
      w(`IEQ_OFS_INJECT, 32'h5);
      w(`IEQ_OFS_CTRL, 32'h1);
      // The clear-status pulse is registered, so it lands one edge later
      @(posedge hclk);
      r(`IEQ_OFS_STATUS, 16'h0040);
      check("empty port", {31'h00000000, qe}, 32'h00000001);
      w(`IEQ_OFS_CTRL, 32'h2);
      w(`IEQ_OFS_INJECT, 32'h7);
      SRC.fire(3'h5, 5'h00, 16'h0);
      r(`IEQ_OFS_STATUS, 16'h0040);
      w(`IEQ_OFS_CTRL, 32'h0);
      w(`IEQ_OFS_INJECT, 32'h8);
      SRC.fire(3'h5, 5'h00, 16'h0);
      r(`IEQ_OFS_STATUS, 16'h0001);
      r(`IEQ_OFS_POP, 16'h0008);
      end_of_test;
   end
endmodule // tb_top
